// ==== fsp_defs.vh ====
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH

// Serial opcodes
`define FSP_OP_WREN      8'h06
`define FSP_OP_WRDI      8'h04
`define FSP_OP_RD_SR1    8'h05
`define FSP_OP_RD_SR2    8'h35
`define FSP_OP_RD_SR3    8'h15
`define FSP_OP_WR_SR1    8'h01
`define FSP_OP_WR_SR2    8'h31
`define FSP_OP_WR_SR3    8'h11
`define FSP_OP_SUSPEND   8'h75
`define FSP_OP_RESUME    8'h7A

// Frame lengths in serial clocks
`define FSP_BITS_CMD     6'd8
`define FSP_BITS_WR      6'd16

// Status word two field positions
`define FSP_SR2_PAUSED   7
`define FSP_SR2_INVERT   6
`define FSP_SR2_LOCK_HI  5
`define FSP_SR2_LOCK_LO  3
`define FSP_SR2_QUAD     1
`define FSP_SR2_LOCKM1   0

// Status word three field positions
`define FSP_SR3_PINSEL   7
`define FSP_SR3_DRV_HI   6
`define FSP_SR3_DRV_LO   5

// Reset values
`define FSP_RST_DRV      2'b10
`define FSP_RST_BIT      1'b0

// Array geometry, 16 MB
`define FSP_ARR_TOP      25'h100_0000
`define FSP_ARR_MAX      24'hFF_FFFF

`endif

// ==== fsp_status_protect.v ====
// Functional notes
// RL1: Lock-down mode (1,0) reverts to (0,0) at power-up
// RL2: Quad select defaults 0; 1 turns pins to data
// RL3: Host avoids quad select with strapped guard pins
// RL4: Three OTP lock bits at 13..11, default 0
// RL5: Lock bits set individually, never cleared; power-cycle reset clears them to 000
// RL6: Invert bit at 14, default 0, steers region
// RL7: Suspend opcode 75H sets erase paused flag
// RL8: Resume 7AH or power cycle clears paused flag
// RL9: Pin select 0 pause, 1 active-low reset
// RL10: Pause and reset only while quad select 0
// RL11: Strength field 00/01/10/11 gives 25..100 percent
// RL12: Codes 000 none, 111 whole array
// RL13: Range bit4 0: fractions 1/64..1/2, top/bottom
// RL14: Range bit4 1: 4K..32K regions, top/bottom
// RL15: Invert protects the exact complement region
// RL16: Write latch clears even on refused writes
// RL17: Range bits writable unless hardware protected
// RL18: Refuse array operation touching protected region
`timescale 1ns/100ps
`include "fsp_defs.vh"

module fsp_status_protect (
  input  wire        REF_CLK,
  input  wire        ARST_N,
  input  wire        CS_N,
  input  wire        SCLK,
  input  wire        SI,
  output wire        SO_O,
  output wire        SO_OE,
  input  wire        WP_IO2_I,
  input  wire        HOLD_IO3_I,
  input  wire        ARR_BUSY,
  input  wire        ARR_OP_REQ,
  input  wire [23:0] ARR_OP_LO,
  input  wire [23:0] ARR_OP_HI,
  output wire        ARR_OP_GRANT,
  output wire        QUAD_PIN_SELECT,
  output wire [1:0]  OUTPUT_STRENGTH,
  output wire [2:0]  SECURITY_LOCK_BITS,
  output wire        ERASE_PAUSED_FLAG,
  output wire        WRITE_ENABLE_LATCH,
  output wire        HW_RESET_ACTIVE
);

  // Pin synchronisers, first stage read only by the second
  reg [1:0] sclk_sync_ff;
  reg [1:0] cs_sync_ff;
  reg [1:0] si_sync_ff;
  reg [1:0] wp_sync_ff;
  reg [1:0] hold_sync_ff;
  reg       sclk_d_ff;
  reg       cs_d_ff;

  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sclk_sync_ff <= 2'b00;
      cs_sync_ff   <= 2'b11;
      si_sync_ff   <= 2'b00;
      wp_sync_ff   <= 2'b11;
      hold_sync_ff <= 2'b11;
      sclk_d_ff    <= 1'b0;
      cs_d_ff      <= 1'b1;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[0], SCLK};
      cs_sync_ff   <= {cs_sync_ff[0], CS_N};
      si_sync_ff   <= {si_sync_ff[0], SI};
      wp_sync_ff   <= {wp_sync_ff[0], WP_IO2_I};
      hold_sync_ff <= {hold_sync_ff[0], HOLD_IO3_I};
      sclk_d_ff    <= sclk_sync_ff[1];
      cs_d_ff      <= cs_sync_ff[1];
    end
  end

  // Status bits
  reg       lock_mode0_ff;
  reg       lock_mode1_ff;
  reg [4:0] range_ff;
  reg       wel_ff;
  reg       quad_ff;
  reg [2:0] sec_lock_ff;
  reg       invert_ff;
  reg       paused_ff;
  reg       pin_sel_ff;
  reg [1:0] drv_ff;

  // Shared pin roles exist only while quad select is clear
  wire pin_roles   = ~quad_ff; // RL2 RL10
  wire pause_act   = pin_roles & ~pin_sel_ff & ~hold_sync_ff[1]; // RL9 RL10
  wire hw_rst      = pin_roles & pin_sel_ff & ~hold_sync_ff[1]; // RL9 RL10
  wire guard_low   = pin_roles & ~wp_sync_ff[1];

  // Pause freezes the serial engine; a frame held high is idle
  wire cs_active   = ~cs_sync_ff[1] & ~hw_rst;
  wire sclk_rise   = sclk_sync_ff[1] & ~sclk_d_ff & cs_active & ~pause_act;
  wire sclk_fall   = ~sclk_sync_ff[1] & sclk_d_ff & cs_active & ~pause_act;
  wire cs_rise     = cs_sync_ff[1] & ~cs_d_ff;

  // Frame shifter
  reg [5:0] bit_cnt_ff;
  reg [7:0] op_ff;
  reg [7:0] shin_ff;
  reg [7:0] data_ff;
  reg [7:0] shout_ff;
  reg       reading_ff;

  wire [7:0] shin_nxt = {shin_ff[6:0], si_sync_ff[1]};

  // Status words as read back
  wire [7:0] sr1 = {lock_mode0_ff, range_ff, wel_ff, ARR_BUSY};
  wire [7:0] sr2 = {paused_ff, invert_ff, sec_lock_ff, 1'b0, quad_ff, lock_mode1_ff};
  wire [7:0] sr3 = {pin_sel_ff, drv_ff, 5'b0_0000};

  reg [7:0] rd_word;
  always @* begin
    case (op_ff)
      `FSP_OP_RD_SR1: rd_word = sr1;
      `FSP_OP_RD_SR2: rd_word = sr2;
      default:        rd_word = sr3;
    endcase
  end

  wire [7:0] shin_op = (bit_cnt_ff == 6'd7) ? shin_nxt : op_ff;
  wire is_read = (shin_op == `FSP_OP_RD_SR1) | (shin_op == `FSP_OP_RD_SR2) |
                 (shin_op == `FSP_OP_RD_SR3);

  // Serial capture on rising edges, shift out on falling edges
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_cnt_ff <= 6'd0;
      op_ff      <= 8'h00;
      shin_ff    <= 8'h00;
      data_ff    <= 8'h00;
      shout_ff   <= 8'h00;
      reading_ff <= 1'b0;
    end else if (!cs_active) begin
      bit_cnt_ff <= 6'd0;
      reading_ff <= 1'b0;
    end else if (sclk_rise) begin
      shin_ff <= shin_nxt;
      if (bit_cnt_ff != 6'd63)
        bit_cnt_ff <= bit_cnt_ff + 6'd1;
      if (bit_cnt_ff == 6'd7) begin
        op_ff      <= shin_nxt;
        reading_ff <= is_read;
      end
      if (bit_cnt_ff == 6'd15)
        data_ff <= shin_nxt;
    end else if (sclk_fall && reading_ff) begin
      // Reload each byte so a status read repeats its word for seven bytes, then shifts zeros
      if (bit_cnt_ff[2:0] == 3'd0)
        shout_ff <= rd_word;
      else
        shout_ff <= {shout_ff[6:0], 1'b0};
    end
  end

  assign SO_O  = shout_ff[7];
  assign SO_OE = reading_ff & cs_active & ~pause_act;

  // Command completes on select release at an exact byte count
  wire done_cmd = cs_rise & ~hw_rst & (bit_cnt_ff == `FSP_BITS_CMD);
  wire done_wr  = cs_rise & ~hw_rst & (bit_cnt_ff == `FSP_BITS_WR);
  wire wr_sr1   = done_wr & (op_ff == `FSP_OP_WR_SR1);
  wire wr_sr2   = done_wr & (op_ff == `FSP_OP_WR_SR2);
  wire wr_sr3   = done_wr & (op_ff == `FSP_OP_WR_SR3);
  wire wr_any   = wr_sr1 | wr_sr2 | wr_sr3;

  // Lock mode 01 with guard low, 10 and 11 all forbid status writes
  wire sr_locked = lock_mode1_ff | (lock_mode0_ff & guard_low); // RL17
  wire sr_write_ok = wel_ff & ~sr_locked & ~ARR_BUSY;

  // Protected region decode for invert clear
  wire [2:0] code    = range_ff[2:0];
  reg  [24:0] size;
  always @* begin
    if (!range_ff[4])
      size = 25'h002_0000 << code; // RL13
    else if (code[2])
      size = 25'h000_8000; // RL14
    else
      size = 25'h000_0800 << code; // RL14
  end

  wire none_code = (code == 3'b000); // RL12
  wire all_code  = (code == 3'b111); // RL12
  wire [24:0] base_lo = range_ff[3] ? 25'h000_0000 : (`FSP_ARR_TOP - size);
  wire [24:0] base_hi = range_ff[3] ? (size - 25'h000_0001) : {1'b0, `FSP_ARR_MAX};
  wire [24:0] reg_lo  = all_code ? 25'h000_0000 : base_lo;
  wire [24:0] reg_hi  = all_code ? {1'b0, `FSP_ARR_MAX} : base_hi;

  // Overlap of target with region, or with its complement when inverted
  wire [24:0] t_lo = {1'b0, ARR_OP_LO};
  wire [24:0] t_hi = {1'b0, ARR_OP_HI};
  wire hit_region  = ~none_code & (t_lo <= reg_hi) & (t_hi >= reg_lo);
  wire hit_compl   = none_code | (t_lo < reg_lo) | (t_hi > reg_hi);
  wire hit_prot    = invert_ff ? hit_compl : hit_region; // RL15 RL6
  assign ARR_OP_GRANT = ARR_OP_REQ & wel_ff & ~hit_prot; // RL18 RL17

  // Status bit update; reset is the power cycle
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lock_mode0_ff <= `FSP_RST_BIT; // RL1
      lock_mode1_ff <= `FSP_RST_BIT; // RL1
      range_ff      <= 5'b0_0000;
      wel_ff        <= `FSP_RST_BIT;
      quad_ff       <= `FSP_RST_BIT; // RL2
      sec_lock_ff   <= 3'b000; // RL4
      invert_ff     <= `FSP_RST_BIT; // RL6
      paused_ff     <= `FSP_RST_BIT; // RL8
      pin_sel_ff    <= `FSP_RST_BIT; // RL9
      drv_ff        <= `FSP_RST_DRV; // RL11
    end else if (hw_rst) begin
      // Reset pin drops volatile state only; lock-down waits for power
      wel_ff    <= 1'b0;
      paused_ff <= 1'b0;
    end else begin
      // Latch clears after any attempt, refused or not
      if (done_cmd && op_ff == `FSP_OP_WREN)
        wel_ff <= 1'b1;
      else if ((done_cmd && op_ff == `FSP_OP_WRDI) || wr_any || ARR_OP_REQ)
        wel_ff <= 1'b0; // RL16
      if (done_cmd && op_ff == `FSP_OP_SUSPEND && ARR_BUSY)
        paused_ff <= 1'b1; // RL7
      else if (done_cmd && op_ff == `FSP_OP_RESUME)
        paused_ff <= 1'b0; // RL8
      if (wr_sr1 && sr_write_ok) begin
        lock_mode0_ff <= data_ff[7];
        range_ff      <= data_ff[6:2]; // RL17
      end
      if (wr_sr2 && sr_write_ok) begin
        invert_ff     <= data_ff[`FSP_SR2_INVERT]; // RL6
        sec_lock_ff   <= sec_lock_ff | data_ff[`FSP_SR2_LOCK_HI:`FSP_SR2_LOCK_LO]; // RL5
        quad_ff       <= data_ff[`FSP_SR2_QUAD]; // RL2
        lock_mode1_ff <= data_ff[`FSP_SR2_LOCKM1];
      end
      if (wr_sr3 && sr_write_ok) begin
        pin_sel_ff <= data_ff[`FSP_SR3_PINSEL]; // RL9
        drv_ff     <= data_ff[`FSP_SR3_DRV_HI:`FSP_SR3_DRV_LO]; // RL11
      end
    end
  end

  assign QUAD_PIN_SELECT    = quad_ff;
  assign OUTPUT_STRENGTH    = drv_ff; // RL11
  assign SECURITY_LOCK_BITS = sec_lock_ff;
  assign ERASE_PAUSED_FLAG  = paused_ff;
  assign WRITE_ENABLE_LATCH = wel_ff;
  assign HW_RESET_ACTIVE    = hw_rst;

endmodule // fsp_status_protect

// ==== fsp_status_protect_assertions.sv ====
`timescale 1ns/100ps
module fsp_status_protect_assertions (
  input wire       REF_CLK,
  input wire       ARST_N,
  input wire       CS_N,
  input wire       SO_OE,
  input wire       HOLD_IO3_I,
  input wire       ARR_BUSY,
  input wire       ARR_OP_REQ,
  input wire       ARR_OP_GRANT,
  input wire       QUAD_PIN_SELECT,
  input wire [1:0] OUTPUT_STRENGTH,
  input wire [2:0] SECURITY_LOCK_BITS,
  input wire       ERASE_PAUSED_FLAG,
  input wire       WRITE_ENABLE_LATCH,
  input wire       HW_RESET_ACTIVE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // Power cycle state, from the second edge of reset so time zero cannot race
  AST_RST_VALUES: assert property (disable iff (1'b0)
    !ARST_N && $past(!ARST_N) |-> !ERASE_PAUSED_FLAG && !QUAD_PIN_SELECT && OUTPUT_STRENGTH == 2'b10)
    else $error("bad reset values");
  // Output enable only inside a frame and never while paused
  AST_SO_OE_IN_FRAME: assert property (
    SO_OE |-> !$past(CS_N, 2) && ($past(HOLD_IO3_I, 2) || QUAD_PIN_SELECT))
    else $error("output enabled outside frame");
  AST_GRANT_NEEDS_WEL: assert property (
    ARR_OP_REQ && ARR_OP_GRANT |-> WRITE_ENABLE_LATCH) else $error("grant without write latch");
  AST_REQ_CLEARS_WEL: assert property (
    ARR_OP_REQ |=> !WRITE_ENABLE_LATCH) else $error("latch kept after array request");
  AST_WEL_AT_FRAME_END: assert property (
    $rose(WRITE_ENABLE_LATCH) |-> $past(CS_N, 2)) else $error("latch set inside a frame");
  AST_PIN_RESET_DUAL_ONLY: assert property (
    HW_RESET_ACTIVE |-> !QUAD_PIN_SELECT) else $error("pin reset in quad mode");
  // Two synchroniser flops between pin and flag
  AST_PIN_RESET_FROM_PIN: assert property (
    HW_RESET_ACTIVE |-> !$past(HOLD_IO3_I, 2)) else $error("pin reset with pin high");
  // Skip the first edge, where past values predate reset
  AST_LOCK_STICKY: assert property (
    $past(ARST_N) |-> (SECURITY_LOCK_BITS & $past(SECURITY_LOCK_BITS)) == $past(SECURITY_LOCK_BITS))
    else $error("lock bit cleared");
  AST_LOCK_AT_FRAME_END: assert property (
    $past(ARST_N) && $changed(SECURITY_LOCK_BITS) |-> $past(CS_N, 2)) else $error("lock moved inside frame");
  AST_PAUSE_NEEDS_BUSY: assert property (
    $rose(ERASE_PAUSED_FLAG) |-> $past(ARR_BUSY)) else $error("paused while idle");
  // Main scenarios
  cover property (ARR_OP_REQ && ARR_OP_GRANT);
  cover property (ARR_OP_REQ && !ARR_OP_GRANT && WRITE_ENABLE_LATCH);
  cover property ($rose(ERASE_PAUSED_FLAG));
  cover property ($rose(HW_RESET_ACTIVE));
endmodule // fsp_status_protect_assertions

bind fsp_status_protect fsp_status_protect_assertions u_fsp_status_protect_assertions (
  .REF_CLK(REF_CLK), .ARST_N(ARST_N), .CS_N(CS_N), .SO_OE(SO_OE), .HOLD_IO3_I(HOLD_IO3_I), .ARR_BUSY(ARR_BUSY),
  .ARR_OP_REQ(ARR_OP_REQ), .ARR_OP_GRANT(ARR_OP_GRANT), .QUAD_PIN_SELECT(QUAD_PIN_SELECT),
  .OUTPUT_STRENGTH(OUTPUT_STRENGTH), .SECURITY_LOCK_BITS(SECURITY_LOCK_BITS),
  .ERASE_PAUSED_FLAG(ERASE_PAUSED_FLAG), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .HW_RESET_ACTIVE(HW_RESET_ACTIVE));

// ==== fsp_host_model.sv ====
`timescale 1ns/100ps
module fsp_host_model (
  input wire  ref_clk,
  input wire  so_o,
  output reg  cs_n,
  output reg  sclk,
  output reg  si
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end
  // Half of the 48 ns link period
  task automatic half;
    repeat (6) @(posedge ref_clk);
  endtask
  // One frame, MSB first; link clock idles low between frames
  task automatic xfer(input int n, input logic [15:0] d, output logic [7:0] q);
    cs_n <= 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      si <= d[i];
      half();
      sclk <= 1'b1;
      q = {q[6:0], so_o};
      half();
      sclk <= 1'b0;
    end
    half();
    cs_n <= 1'b1;
    si <= ~si; // Released line must not keep a stale value
    half();
  endtask
endmodule // fsp_host_model

// ==== testbench.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
  logic REF_CLK, ARST_N, CS_N, SCLK, SI, SO_O, WP_IO2_I, HOLD_IO3_I, ARR_BUSY, ARR_OP_REQ, ARR_OP_GRANT;
  logic QUAD_PIN_SELECT, ERASE_PAUSED_FLAG, WRITE_ENABLE_LATCH, HW_RESET_ACTIVE, SO_OE;
  logic [23:0] ARR_OP_LO, ARR_OP_HI;
  logic [1:0] OUTPUT_STRENGTH;
  logic [2:0] SECURITY_LOCK_BITS;
  logic [7:0] q;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  fsp_status_protect u_fsp_status_protect (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CS_N(CS_N), .SCLK(SCLK),
    .SI(SI), .SO_O(SO_O), .SO_OE(SO_OE), .WP_IO2_I(WP_IO2_I), .HOLD_IO3_I(HOLD_IO3_I), .ARR_BUSY(ARR_BUSY),
    .ARR_OP_REQ(ARR_OP_REQ), .ARR_OP_LO(ARR_OP_LO), .ARR_OP_HI(ARR_OP_HI), .ARR_OP_GRANT(ARR_OP_GRANT),
    .QUAD_PIN_SELECT(QUAD_PIN_SELECT), .OUTPUT_STRENGTH(OUTPUT_STRENGTH), .SECURITY_LOCK_BITS(SECURITY_LOCK_BITS),
    .ERASE_PAUSED_FLAG(ERASE_PAUSED_FLAG), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .HW_RESET_ACTIVE(HW_RESET_ACTIVE));
  fsp_host_model u_fsp_host_model (.ref_clk(REF_CLK), .so_o(SO_O), .cs_n(CS_N), .sclk(SCLK), .si(SI));
  task end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Clock and hang guard
  initial begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_sim();
    end
  end
  // Power cycle through the async reset
  task pwr(input int n);
    @(posedge REF_CLK) ARST_N <= 1'b0;
    repeat (n) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    repeat (4) @(posedge REF_CLK);
  endtask
  task cmd(input logic [7:0] op);
    u_fsp_host_model.xfer(8, {8'h00, op}, q);
  endtask
  task w(input logic [7:0] op, input logic [7:0] d);
    cmd(8'h06);
    u_fsp_host_model.xfer(16, {op, d}, q);
  endtask
  task rd(input logic [7:0] op);
    u_fsp_host_model.xfer(16, {op, 8'h00}, q);
  endtask
  // Set region, then ask for one array operation
  task pc(input logic inv, input logic [4:0] bp, input logic [23:0] lo, input logic [23:0] hi, input logic ok);
    w(8'h01, {1'b0, bp, 2'b00});
    w(8'h31, {1'b0, inv, 6'h00});
    cmd(8'h06);
    @(posedge REF_CLK) {ARR_OP_REQ, ARR_OP_LO, ARR_OP_HI} <= {1'b1, lo, hi};
    #1 `CHK(ARR_OP_GRANT, ok)
    @(posedge REF_CLK) ARR_OP_REQ <= 1'b0;
    #1 `CHK(WRITE_ENABLE_LATCH, 1'b0)
  endtask
  task t_defaults;
    rd(8'h35); `CHK(q, 8'h00)
    rd(8'h15); `CHK(q, 8'h40)
    `CHK(SO_OE, 1'b0)
    for (int i = 0; i < 4; i++) begin
      w(8'h11, {1'b0, 2'(i), 5'h00}); `CHK(OUTPUT_STRENGTH, 2'(i))
    end
  endtask
  task t_protect;
    pc(0, 5'h00, 24'h00_0000, 24'hFF_FFFF, 1);
    pc(0, 5'h1F, 24'h00_0000, 24'h00_0000, 0);
    pc(0, 5'h01, 24'hFB_FFFF, 24'hFB_FFFF, 1);
    pc(0, 5'h01, 24'hFB_FFFF, 24'hFC_0000, 0);
    pc(0, 5'h0E, 24'h7F_FFFF, 24'h7F_FFFF, 0);
    pc(0, 5'h11, 24'hFF_F000, 24'hFF_F000, 0);
    pc(0, 5'h11, 24'h00_0000, 24'hFF_EFFF, 1);
    pc(0, 5'h1D, 24'h00_7FFF, 24'h00_7FFF, 0);
    pc(1, 5'h11, 24'hFF_F000, 24'hFF_FFFF, 1);
    pc(1, 5'h11, 24'hFF_EFFF, 24'hFF_EFFF, 0);
    pc(1, 5'h07, 24'h00_0000, 24'hFF_FFFF, 1);
    pc(0, 5'h00, 24'h00_0000, 24'h00_0000, 1);
    // Latch already cleared, so a second request is refused
    @(posedge REF_CLK) ARR_OP_REQ <= 1'b1;
    #1 `CHK(ARR_OP_GRANT, 1'b0)
    @(posedge REF_CLK) ARR_OP_REQ <= 1'b0;
  endtask
  task t_suspend;
    @(posedge REF_CLK) ARR_BUSY <= 1'b1;
    cmd(8'h75); rd(8'h35); `CHK(q[7], 1'b1)
    cmd(8'h7A); `CHK(ERASE_PAUSED_FLAG, 1'b0)
    cmd(8'h75); `CHK(ERASE_PAUSED_FLAG, 1'b1)
    pwr(2); `CHK(ERASE_PAUSED_FLAG, 1'b0)
    ARR_BUSY <= 1'b0;
  endtask
  task t_lock;
    w(8'h31, 8'h01); w(8'h31, 8'h40); `CHK(WRITE_ENABLE_LATCH, 1'b0)
    rd(8'h35); `CHK(q, 8'h01)
    pwr(2); w(8'h31, 8'h40); rd(8'h35); `CHK(q, 8'h40)
    w(8'h31, 8'h08); w(8'h31, 8'h00); `CHK(SECURITY_LOCK_BITS, 3'b001)
    w(8'h31, 8'h20); rd(8'h35); `CHK(q, 8'h28)
    // Hardware protected mode: guard low blocks range writes
    w(8'h01, 8'h80);
    @(posedge REF_CLK) WP_IO2_I <= 1'b0;
    w(8'h01, 8'h7C); rd(8'h05); `CHK(q, 8'h80)
    @(posedge REF_CLK) WP_IO2_I <= 1'b1;
    w(8'h01, 8'h00); rd(8'h05); `CHK(q, 8'h00)
  endtask
  // Guard and pause pins always driven, never strapped
  task t_pins;
    // Pause role: no reset, and a frame sent while paused is lost
    @(posedge REF_CLK) HOLD_IO3_I <= 1'b0;
    repeat (6) @(posedge REF_CLK); `CHK(HW_RESET_ACTIVE, 1'b0)
    cmd(8'h06); `CHK(WRITE_ENABLE_LATCH, 1'b0)
    @(posedge REF_CLK) HOLD_IO3_I <= 1'b1;
    w(8'h11, 8'hC0);
    @(posedge REF_CLK) HOLD_IO3_I <= 1'b0;
    repeat (6) @(posedge REF_CLK); `CHK(HW_RESET_ACTIVE, 1'b1)
    HOLD_IO3_I <= 1'b1;
    repeat (6) @(posedge REF_CLK); w(8'h31, 8'h02); `CHK(QUAD_PIN_SELECT, 1'b1)
    @(posedge REF_CLK) HOLD_IO3_I <= 1'b0;
    repeat (6) @(posedge REF_CLK); `CHK(HW_RESET_ACTIVE, 1'b0)
  endtask
  initial begin
    {ARST_N, WP_IO2_I, HOLD_IO3_I, ARR_BUSY, ARR_OP_REQ, ARR_OP_LO, ARR_OP_HI} = {4'h6, 1'b0, 48'h0};
    pwr(5);
    t_defaults; t_protect; t_suspend; t_lock; t_pins;
    end_sim();
  end
endmodule // testbench
